// >>> timer16_consts.svh
// Purpose: Shared constants for the 16-bit timer mode-control block.
// Assumes: Included by bare name from every design file.
// Notes:   Definitions only.
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// ==========================================================
// Counter limits
`define CNT_WIDTH        16
`define CNT_BOTTOM       16'h0000
`define CNT_MAX          16'hFFFF
`define TOP_FIXED_8BIT   16'h00FF
`define TOP_FIXED_9BIT   16'h01FF
`define TOP_FIXED_10BIT  16'h03FF

// ==========================================================
// Waveform generation mode codes
`define WGM_NORMAL       4'h0
`define WGM_FPWM_8BIT    4'h5
`define WGM_FPWM_9BIT    4'h6
`define WGM_FPWM_10BIT   4'h7
`define WGM_CTC_A        4'h4
`define WGM_CTC_CAP      4'hC
`define WGM_FPWM_CAP     4'hE
`define WGM_FPWM_A       4'hF

// ==========================================================
// Compare output mode codes
`define COM_NONE         2'h0
`define COM_TOGGLE       2'h1
`define COM_CLEAR        2'h2
`define COM_SET          2'h3

// ==========================================================
// Flag vector layout
`define FLAG_COUNT       2
`define FLAG_OVF         0
`define FLAG_CMPA        1
`define FLAG_CAP         2
`define FLAG_RESET       3'h0

`endif

// >>> timer16_pkg.sv
// Purpose: Types and mode decoding for the 16-bit timer.
// Assumes: timer16_consts.svh provides the codes.
// Notes:   Decoding is shared by the top and the output unit.
`include "timer16_consts.svh"

package timer16_pkg;

   // ==========================================================
   // Counting classes
   typedef enum logic [2:0] {
      CLS_NORMAL     = 3'h0,
      CLS_CTC_A      = 3'h1,
      CLS_CTC_CAP    = 3'h2,
      CLS_FPWM_FIXED = 3'h3,
      CLS_FPWM_CAP   = 3'h4,
      CLS_FPWM_A     = 3'h5
   } count_class_t;

   // Modes outside this block count as normal mode.
   function automatic count_class_t decode_class(input logic [3:0] wgm);
      case (wgm)
         `WGM_CTC_A:      decode_class = CLS_CTC_A;
         `WGM_CTC_CAP:    decode_class = CLS_CTC_CAP;
         `WGM_FPWM_8BIT,
         `WGM_FPWM_9BIT,
         `WGM_FPWM_10BIT: decode_class = CLS_FPWM_FIXED;
         `WGM_FPWM_CAP:   decode_class = CLS_FPWM_CAP;
         `WGM_FPWM_A:     decode_class = CLS_FPWM_A;
         default:         decode_class = CLS_NORMAL;
      endcase
   endfunction

   function automatic logic is_fpwm(input count_class_t cls);
      is_fpwm = (cls == CLS_FPWM_FIXED) || (cls == CLS_FPWM_CAP) || (cls == CLS_FPWM_A);
   endfunction

endpackage

// >>> timer16_flag_bank.sv
// Purpose: Sticky event flags for the timer.
// Assumes: Set and clear strobes are on the same clock.
// Notes:   A set in the cycle of a clear wins, so no event is lost.
`timescale 1ns/100ps
`include "timer16_consts.svh"

module timer16_flag_bank (
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   // Events
   input  wire logic [`FLAG_COUNT:0]   i_set,
   input  wire logic [`FLAG_COUNT:0]   i_clear,
   // Flags
   output logic      [`FLAG_COUNT:0]   o_flag
);

   logic [`FLAG_COUNT:0] flag_q;
   logic [`FLAG_COUNT:0] flag_d;

   // ==========================================================
   // Next state
   genvar gi;
   generate
      for (gi = 0; gi <= `FLAG_COUNT; gi++) begin : g_flag
         always_comb begin
            flag_d[gi] = i_set[gi] | (flag_q[gi] & ~i_clear[gi]);
         end
      end
   endgenerate

   // ==========================================================
   // Registers
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         flag_q <= `FLAG_RESET;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign o_flag = flag_q;

endmodule // timer16_flag_bank

// >>> timer16_output_unit.sv
// Purpose: Compare output A state machine of the waveform generator.
// Assumes: Match and top strobes are already qualified by the timer tick.
// Notes:   The state survives mode changes; only reset, match, top and force strobes change it.
`timescale 1ns/100ps
`include "timer16_consts.svh"

module timer16_output_unit
   import timer16_pkg::*;
(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_reset_n,
   // Configuration
   input  wire count_class_t i_class,
   input  wire logic [1:0]   i_compare_output_mode,
   // Events
   input  wire logic         i_match,
   input  wire logic         i_top,
   input  wire logic         i_force_compare_strobe,
   // State
   output logic              o_compare_output_state
);

   logic state_q;
   logic state_d;
   logic pwm;

   // ==========================================================
   // Next state
   always_comb begin
      pwm     = is_fpwm(i_class);
      state_d = state_q;
      if (!pwm) begin
         if (i_match || i_force_compare_strobe) begin
            case (i_compare_output_mode)
               `COM_TOGGLE: state_d = ~state_q;
               `COM_CLEAR:  state_d = 1'b0;
               `COM_SET:    state_d = 1'b1;
               default:     state_d = state_q;
            endcase
         end
      end else begin
         // Match takes priority at top, so compare equal to top gives a steady level.
         case (i_compare_output_mode)
            `COM_TOGGLE: begin
               if (i_match && (i_class == CLS_FPWM_A)) begin
                  state_d = ~state_q;
               end
            end
            `COM_CLEAR: begin
               if (i_match) begin
                  state_d = 1'b1;
               end else if (i_top) begin
                  state_d = 1'b0;
               end
            end
            `COM_SET: begin
               if (i_match) begin
                  state_d = 1'b0;
               end else if (i_top) begin
                  state_d = 1'b1;
               end
            end
            default: state_d = state_q;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_q <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_compare_output_state = state_q;

endmodule // timer16_output_unit

// >>> timer16_mode_ctrl.sv
// Purpose: 16-bit timer counting core for normal, clear on match and fast PWM modes.
// Assumes: i_tick is a one-cycle enable from the prescaler on i_clk.
// Notes:   Channel A only; other modes count as normal mode.
// Behaviour
// - Compare output mode zero leaves the compare output state unchanged on match.
// - A new compare output mode governs the very next compare match.
// - Force strobe in non-PWM modes applies the output action at once.
// - Only the waveform mode shapes counting; output mode never alters it.
// - Mode zero always counts up and wraps from 0xFFFF to zero.
// - Normal mode sets overflow flag in the tick the count becomes zero.
// - Counter only sets overflow flag; servicing clears it.
// - Clear on match resets at compare A (mode 4) or capture (mode 12).
// - Clear on match sets the flag of the register defining top.
// - Clear on match top is unbuffered; top below count wraps through maximum.
// - Toggle output mode inverts compare output A on every match, but in fast PWM only in mode 15.
// - Compare output A reaches the pin only when its direction bit is one.
// - Clear on match sets overflow flag when count passes maximum to zero.
// - Modes 5, 6, 7, 14, 15 are single-slope fast PWM.
// - Non-inverting fast PWM sets on match, clears at top; inverting opposite.
// - Fast PWM top is fixed, capture or compare A; clear one tick later.
// - Fast PWM sets overflow at top, with the top register's flag.
// - Top below a compare value yields no match for that register.
// - Fixed resolution fast PWM masks compare writes above the resolution.
// - Capture as top acts at once; a low value wraps through maximum.
// - Fast PWM compare A writes are buffered and loaded at top.
// - Fast PWM output mode 2 is non-inverted, 3 inverted.
// - A compare match sets the compare flag in the same tick as the match.
`timescale 1ns/100ps
`include "timer16_consts.svh"

module timer16_mode_ctrl
   import timer16_pkg::*;
(
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   // Prescaler
   input  wire logic                   i_tick,
   // Configuration
   input  wire logic [3:0]             i_waveform_gen_mode,
   input  wire logic [1:0]             i_compare_output_mode,
   input  wire logic                   i_compare_a_pin_direction,
   input  wire logic                   i_port_value_a,
   // Register writes
   input  wire logic                   i_count_wr,
   input  wire logic [`CNT_WIDTH-1:0]  i_count_wdata,
   input  wire logic                   i_compare_a_wr,
   input  wire logic [`CNT_WIDTH-1:0]  i_compare_a_wdata,
   input  wire logic                   i_capture_wr,
   input  wire logic [`CNT_WIDTH-1:0]  i_capture_wdata,
   input  wire logic                   i_force_compare_strobe,
   // Flag clears
   input  wire logic                   i_overflow_clear,
   input  wire logic                   i_compare_a_clear,
   input  wire logic                   i_capture_clear,
   // Register reads
   output logic      [`CNT_WIDTH-1:0]  o_count_value,
   output logic      [`CNT_WIDTH-1:0]  o_compare_a_value,
   output logic      [`CNT_WIDTH-1:0]  o_capture_value,
   // Flags
   output logic                        o_overflow_flag,
   output logic                        o_compare_a_flag,
   output logic                        o_capture_flag,
   // Compare output
   output logic                        o_compare_output_a,
   output logic                        o_pin_a,
   output logic                        o_pin_a_oe
);

   // ==========================================================
   // State
   logic [`CNT_WIDTH-1:0] count_q;
   logic [`CNT_WIDTH-1:0] count_d;
   logic [`CNT_WIDTH-1:0] cmpa_buf_q;
   logic [`CNT_WIDTH-1:0] cmpa_buf_d;
   logic [`CNT_WIDTH-1:0] cmpa_act_q;
   logic [`CNT_WIDTH-1:0] cmpa_act_d;
   logic [`CNT_WIDTH-1:0] capture_q;
   logic [`CNT_WIDTH-1:0] capture_d;
   logic                  block_q;
   logic                  block_d;
   logic                  pin_q;
   logic                  pin_d;
   logic                  pin_oe_q;
   logic                  pin_oe_d;

   // ==========================================================
   // Decode
   count_class_t          cls;
   logic                  pwm;
   logic [`CNT_WIDTH-1:0] top_value;
   logic [`CNT_WIDTH-1:0] fixed_top;
   logic [`CNT_WIDTH-1:0] write_mask;
   logic                  top_defined;
   logic                  at_top;
   logic                  match_a;
   logic                  wrap;
   logic [`FLAG_COUNT:0]  flag_set;
   logic [`FLAG_COUNT:0]  flag_clear;
   logic [`FLAG_COUNT:0]  flag_vec;
   logic                  state_a;

   always_comb begin
      cls = decode_class(i_waveform_gen_mode);
      pwm = is_fpwm(cls);
      case (i_waveform_gen_mode)
         `WGM_FPWM_8BIT: fixed_top = `TOP_FIXED_8BIT;
         `WGM_FPWM_9BIT: fixed_top = `TOP_FIXED_9BIT;
         default:        fixed_top = `TOP_FIXED_10BIT;
      endcase
      case (cls)
         CLS_CTC_A,
         CLS_FPWM_A:     top_value = cmpa_act_q;
         CLS_CTC_CAP,
         CLS_FPWM_CAP:   top_value = capture_q;
         CLS_FPWM_FIXED: top_value = fixed_top;
         default:        top_value = `CNT_MAX;
      endcase
      write_mask  = (cls == CLS_FPWM_FIXED) ? fixed_top : `CNT_MAX;
      top_defined = (cls != CLS_NORMAL);
      // Count writes block matches for one tick, including the top match.
      at_top  = top_defined && (count_q == top_value) && !block_q;
      match_a = (count_q == cmpa_act_q) && (cmpa_act_q <= top_value) && !block_q;
      wrap    = (count_q == `CNT_MAX);
   end

   // ==========================================================
   // Counter and compare registers
   always_comb begin
      count_d    = count_q;
      cmpa_buf_d = cmpa_buf_q;
      cmpa_act_d = cmpa_act_q;
      capture_d  = i_capture_wr ? i_capture_wdata : capture_q;
      block_d    = block_q;
      if (i_tick) begin
         block_d = 1'b0;
         if (at_top) begin
            count_d = `CNT_BOTTOM;
         end else begin
            count_d = count_q + 16'h0001;
         end
         if (pwm && at_top) begin
            cmpa_act_d = cmpa_buf_q;
         end
      end
      if (i_count_wr) begin
         count_d = i_count_wdata;
         block_d = 1'b1;
      end
      if (i_compare_a_wr) begin
         cmpa_buf_d = i_compare_a_wdata & write_mask;
         if (!pwm) begin
            cmpa_act_d = i_compare_a_wdata;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         count_q    <= `CNT_BOTTOM;
         cmpa_buf_q <= `CNT_BOTTOM;
         cmpa_act_q <= `CNT_BOTTOM;
         capture_q  <= `CNT_BOTTOM;
         block_q    <= 1'b0;
      end else begin
         count_q    <= count_d;
         cmpa_buf_q <= cmpa_buf_d;
         cmpa_act_q <= cmpa_act_d;
         capture_q  <= capture_d;
         block_q    <= block_d;
      end
   end

   // ==========================================================
   // Flags
   always_comb begin
      flag_set = `FLAG_RESET;
      if (i_tick && !i_count_wr) begin
         if (pwm) begin
            flag_set[`FLAG_OVF] = at_top;
         end else begin
            flag_set[`FLAG_OVF] = wrap;
         end
         flag_set[`FLAG_CMPA] = match_a;
         flag_set[`FLAG_CAP]  = at_top && ((cls == CLS_CTC_CAP) || (cls == CLS_FPWM_CAP));
      end
      flag_clear = {i_capture_clear, i_compare_a_clear, i_overflow_clear};
   end

   timer16_flag_bank u_flags (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_set     (flag_set),
      .i_clear   (flag_clear),
      .o_flag    (flag_vec)
   );

   // ==========================================================
   // Compare output
   timer16_output_unit u_out (
      .i_clk                  (i_clk),
      .i_reset_n              (i_reset_n),
      .i_class                (cls),
      .i_compare_output_mode  (i_compare_output_mode),
      .i_match                (i_tick && match_a),
      .i_top                  (i_tick && at_top),
      .i_force_compare_strobe (i_force_compare_strobe && !pwm),
      .o_compare_output_state (state_a)
   );

   // The pin lags the internal state by one clock so every output is a flop.
   always_comb begin
      pin_d    = (i_compare_output_mode != `COM_NONE) ? state_a : i_port_value_a;
      pin_oe_d = i_compare_a_pin_direction;
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         pin_q    <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pin_q    <= pin_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   // ==========================================================
   // Outputs
   assign o_count_value      = count_q;
   assign o_compare_a_value  = cmpa_buf_q;
   assign o_capture_value    = capture_q;
   assign o_overflow_flag    = flag_vec[`FLAG_OVF];
   assign o_compare_a_flag   = flag_vec[`FLAG_CMPA];
   assign o_capture_flag     = flag_vec[`FLAG_CAP];
   assign o_compare_output_a = state_a;
   assign o_pin_a            = pin_q;
   assign o_pin_a_oe         = pin_oe_q;

endmodule // timer16_mode_ctrl

// >>> timer16_mode_ctrl_chk.sv
// Purpose: Concurrent checks on the ports of the timer mode-control block.
// Assumes: Bound to every timer16_mode_ctrl instance; one clock domain.
// Notes:   A count write blocks match and top events until the next tick, so a helper tracks that window.
`timescale 1ns/100ps

// ==========================================================
// Checker
module timer16_mode_ctrl_chk (
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   // Controls
   input wire logic        i_tick,
   input wire logic [3:0]  i_waveform_gen_mode,
   input wire logic [1:0]  i_compare_output_mode,
   input wire logic        i_compare_a_pin_direction,
   input wire logic        i_count_wr,
   input wire logic        i_compare_a_wr,
   input wire logic [15:0] i_compare_a_wdata,
   input wire logic        i_force_compare_strobe,
   input wire logic        i_overflow_clear,
   // Observed outputs
   input wire logic [15:0] o_count_value,
   input wire logic [15:0] o_compare_a_value,
   input wire logic        o_overflow_flag,
   input wire logic        o_compare_a_flag,
   input wire logic        o_compare_output_a,
   input wire logic        o_pin_a,
   input wire logic        o_pin_a_oe
);
   logic blk_d;
   logic blk_q;
   logic ok;
   always_comb begin
      blk_d = i_count_wr ? 1'b1 : (i_tick ? 1'b0 : blk_q);
   end
   always_ff @(posedge i_clk) begin
      blk_q <= i_reset_n ? blk_d : 1'b0;
   end
   assign ok = i_tick && !i_count_wr && !blk_q;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   property p_ovf_sticky;
      o_overflow_flag && !i_overflow_clear |=> o_overflow_flag;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
   property p_hold;
      !i_tick && !i_count_wr |=> $stable(o_count_value);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved without tick");
   property p_wrap;
      ok && i_waveform_gen_mode == 4'h0 && o_count_value == 16'hFFFF |=> o_count_value == 16'h0000 && o_overflow_flag;
   endproperty
   a_wrap: assert property (p_wrap) else $error("normal wrap wrong");
   property p_oe;
      1'b1 |=> o_pin_a_oe == $past(i_compare_a_pin_direction);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   property p_com_zero;
      i_compare_output_mode == 2'h0 |=> $stable(o_compare_output_a);
   endproperty
   a_com_zero: assert property (p_com_zero) else $error("output moved with mode zero");
   property p_force;
      i_force_compare_strobe && i_compare_output_mode == 2'h3 &&
         (i_waveform_gen_mode == 4'h0 || i_waveform_gen_mode == 4'h4) |=> o_compare_output_a;
   endproperty
   a_force: assert property (p_force) else $error("force did not set output");
   property p_pin;
      i_compare_output_mode != 2'h0 |=> o_pin_a == $past(o_compare_output_a);
   endproperty
   a_pin: assert property (p_pin) else $error("pin does not follow output");
   property p_fixed_top;
      ok && i_waveform_gen_mode == 4'h5 && o_count_value == 16'h00FF |=> o_count_value == 16'h0000 && o_overflow_flag;
   endproperty
   a_fixed_top: assert property (p_fixed_top) else $error("fixed top wrong");
   property p_mask;
      i_compare_a_wr && i_waveform_gen_mode == 4'h5 |=> o_compare_a_value == ($past(i_compare_a_wdata) & 16'h00FF);
   endproperty
   a_mask: assert property (p_mask) else $error("compare write not masked");
   property p_ctc;
      ok && i_waveform_gen_mode == 4'h4 && o_count_value == o_compare_a_value |=> o_count_value == 16'h0000 ##0 o_compare_a_flag;
   endproperty
   a_ctc: assert property (p_ctc) else $error("clear on match wrong");
endmodule // timer16_mode_ctrl_chk

bind timer16_mode_ctrl timer16_mode_ctrl_chk u_chk (.*);

// >>> tb_timer16_mode_ctrl.sv
// Purpose: Self-checking bench for the timer mode-control block.
// Assumes: Inputs change at the falling edge; ticks are driven by the bench.
// Notes:   A count write blocks matches on the next tick but the count still advances on it.
`timescale 1ns/100ps

// ==========================================================
// Bench
module tb_timer16_mode_ctrl;
   logic i_clk, i_reset_n, i_tick, i_compare_a_pin_direction, i_port_value_a;
   logic [3:0] i_waveform_gen_mode;
   logic [1:0] i_compare_output_mode;
   logic i_count_wr, i_compare_a_wr, i_capture_wr, i_force_compare_strobe;
   logic [15:0] i_count_wdata, i_compare_a_wdata, i_capture_wdata;
   logic i_overflow_clear, i_compare_a_clear, i_capture_clear;
   logic [15:0] o_count_value, o_compare_a_value, o_capture_value;
   logic o_overflow_flag, o_compare_a_flag, o_capture_flag, o_compare_output_a, o_pin_a, o_pin_a_oe;
   int n_fail = 0;
   int tests_run = 0;

   timer16_mode_ctrl uut (.*);

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         i_tick = 1'b1;
         @(negedge i_clk);
      end
      i_tick = 1'b0;
   endtask
   task automatic wr(input int sel, input logic [15:0] d);
      i_count_wr = (sel == 0);
      i_compare_a_wr = (sel == 1);
      i_capture_wr = (sel == 2);
      i_count_wdata = d;
      i_compare_a_wdata = d;
      i_capture_wdata = d;
      @(negedge i_clk);
      i_count_wr = 1'b0;
      i_compare_a_wr = 1'b0;
      i_capture_wr = 1'b0;
   endtask
   task automatic clr;
      {i_overflow_clear, i_compare_a_clear, i_capture_clear} = 3'h7;
      @(negedge i_clk);
      {i_overflow_clear, i_compare_a_clear, i_capture_clear} = 3'h0;
   endtask
   task automatic force_cmp;
      i_force_compare_strobe = 1'b1;
      @(negedge i_clk);
      i_force_compare_strobe = 1'b0;
   endtask

   task automatic test_normal;
      i_waveform_gen_mode = 4'h0;
      wr(0, 16'hFFFE);
      ticks(1);
      chk("count", 16'hFFFF, o_count_value);
      chkb("ovf", 1'b0, o_overflow_flag);
      ticks(1);
      chk("count", 16'h0000, o_count_value);
      chkb("ovf", 1'b1, o_overflow_flag);
      ticks(3);
      chkb("ovf", 1'b1, o_overflow_flag);
      repeat (5) @(negedge i_clk);
      chk("count", 16'h0003, o_count_value);
      clr();
      chkb("ovf", 1'b0, o_overflow_flag);
      $display("test normal done");
   endtask

   task automatic test_ctc_out;
      i_waveform_gen_mode = 4'h4;
      i_compare_output_mode = 2'h1;
      i_compare_a_pin_direction = 1'b1;
      wr(1, 16'h0002);
      wr(0, 16'h0000);
      clr();
      ticks(3);
      chk("count", 16'h0000, o_count_value);
      chkb("cmp flag", 1'b1, o_compare_a_flag);
      chkb("out", 1'b1, o_compare_output_a);
      @(negedge i_clk);
      chkb("pin", 1'b1, o_pin_a);
      chkb("oe", 1'b1, o_pin_a_oe);
      ticks(3);
      chkb("out", 1'b0, o_compare_output_a);
      i_compare_output_mode = 2'h0;
      i_port_value_a = 1'b1;
      ticks(3);
      chkb("out", 1'b0, o_compare_output_a);
      chk("count", 16'h0000, o_count_value);
      chkb("pin", 1'b1, o_pin_a);
      i_compare_output_mode = 2'h3;
      clr();
      force_cmp();
      chkb("out", 1'b1, o_compare_output_a);
      chkb("cmp flag", 1'b0, o_compare_a_flag);
      chk("count", 16'h0000, o_count_value);
      i_compare_output_mode = 2'h2;
      ticks(3);
      chkb("out", 1'b0, o_compare_output_a);
      i_compare_a_pin_direction = 1'b0;
      @(negedge i_clk);
      chkb("oe", 1'b0, o_pin_a_oe);
      $display("test clear on match output done");
   endtask

   task automatic test_ctc_top;
      wr(1, 16'h0005);
      wr(0, 16'hFFFD);
      clr();
      ticks(3);
      chk("count", 16'h0000, o_count_value);
      chkb("ovf", 1'b1, o_overflow_flag);
      chkb("cmp flag", 1'b0, o_compare_a_flag);
      ticks(6);
      chk("count", 16'h0000, o_count_value);
      chkb("cmp flag", 1'b1, o_compare_a_flag);
      i_waveform_gen_mode = 4'hC;
      wr(2, 16'h0003);
      wr(0, 16'h0000);
      clr();
      ticks(4);
      chk("count", 16'h0000, o_count_value);
      chkb("cap flag", 1'b1, o_capture_flag);
      chkb("ovf", 1'b0, o_overflow_flag);
      chkb("cmp flag", 1'b0, o_compare_a_flag);
      $display("test clear on match top done");
   endtask

   task automatic test_fpwm_buf;
      i_waveform_gen_mode = 4'hF;
      wr(1, 16'h0007);
      chk("cmp buf", 16'h0007, o_compare_a_value);
      wr(0, 16'h0000);
      clr();
      ticks(6);
      chk("count", 16'h0000, o_count_value);
      chkb("ovf", 1'b1, o_overflow_flag);
      chkb("cmp flag", 1'b1, o_compare_a_flag);
      clr();
      ticks(7);
      chk("count", 16'h0007, o_count_value);
      chkb("ovf", 1'b0, o_overflow_flag);
      ticks(1);
      chk("count", 16'h0000, o_count_value);
      chkb("ovf", 1'b1, o_overflow_flag);
      $display("test fast pwm buffer done");
   endtask

   task automatic test_fpwm_out;
      i_waveform_gen_mode = 4'hE;
      i_compare_output_mode = 2'h2;
      wr(2, 16'h0009);
      wr(1, 16'h0004);
      wr(0, 16'h0008);
      clr();
      ticks(2);
      chkb("cap flag", 1'b1, o_capture_flag);
      chkb("out", 1'b0, o_compare_output_a);
      ticks(5);
      chkb("out", 1'b1, o_compare_output_a);
      ticks(5);
      chkb("out", 1'b0, o_compare_output_a);
      chk("count", 16'h0000, o_count_value);
      i_compare_output_mode = 2'h3;
      ticks(10);
      chkb("out", 1'b1, o_compare_output_a);
      force_cmp();
      chkb("out", 1'b1, o_compare_output_a);
      ticks(5);
      chkb("out", 1'b0, o_compare_output_a);
      wr(2, 16'h0003);
      ticks(2);
      chk("count", 16'h0007, o_count_value);
      $display("test fast pwm output done");
   endtask

   task automatic test_fixed;
      i_waveform_gen_mode = 4'h5;
      wr(1, 16'h1234);
      chk("cmp buf", 16'h0034, o_compare_a_value);
      wr(0, 16'h00FE);
      clr();
      ticks(2);
      chk("count", 16'h0000, o_count_value);
      chkb("ovf", 1'b1, o_overflow_flag);
      i_waveform_gen_mode = 4'hE;
      clr();
      ticks(8);
      chkb("cmp flag", 1'b0, o_compare_a_flag);
      chkb("cap flag", 1'b1, o_capture_flag);
      $display("test fixed top done");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      {i_reset_n, i_tick, i_compare_a_pin_direction, i_port_value_a, i_force_compare_strobe} = 5'h0;
      {i_count_wr, i_compare_a_wr, i_capture_wr, i_overflow_clear, i_compare_a_clear, i_capture_clear} = 6'h0;
      i_waveform_gen_mode = 4'h0;
      i_compare_output_mode = 2'h0;
      {i_count_wdata, i_compare_a_wdata, i_capture_wdata} = 48'h0;
      repeat (12) @(negedge i_clk);
      i_reset_n = 1'b1;
      test_normal();
      test_ctc_out();
      test_ctc_top();
      test_fpwm_buf();
      test_fpwm_out();
      test_fixed();
      test_done();
   end

   // A hang in any wait would otherwise leave the run without a verdict.
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule // tb_timer16_mode_ctrl
